// ===== daalcs_pkg.sv
package daalcs_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [3:0] IDX_IRQ_MASK = 4'h3;
   localparam logic [3:0] IDX_IRQ_STAT = 4'h4;
   localparam logic [3:0] IDX_HOOK = 4'h5;
   localparam logic [3:0] IDX_PWR = 4'h6;
   localparam logic [3:0] IDX_RATE = 4'h7;
   localparam logic [3:0] IDX_RSV_A = 4'h8;
   localparam logic [3:0] IDX_RSV_B = 4'h9;
   localparam logic [3:0] IDX_LOOP = 4'hA;
   localparam logic [3:0] IDX_REV = 4'hB;
   localparam logic [3:0] IDX_LSTAT = 4'hC;

   // Field positions
   localparam int B_RING_NEG = 6;
   localparam int B_RING_POS = 5;
   localparam int B_MONITOR = 3;
   localparam int B_RING = 2;
   localparam int B_OFFHOOK = 0;
   localparam int B_LINE_PD = 4;
   localparam int B_LOGIC_PD = 3;
   localparam int B_LOOPBACK = 0;
   localparam int B_FRAME = 6;
   localparam int B_FLOSS = 5;
   localparam int B_OVL = 2;

   // Reset values
   localparam logic RST_OFFHOOK = 1'b0;
   localparam logic RST_MONITOR = 1'b0;
   localparam logic RST_LINE_PD = 1'b1;
   localparam logic RST_LOGIC_PD = 1'b0;
   localparam logic [3:0] RST_RATE = 4'h1;
   localparam logic RST_LOOPBACK = 1'b0;
   localparam logic [3:0] RATE_LAST = 4'h9;

   // Loop current levels
   localparam logic [4:0] LOOP_SAT = 5'h1F;
   localparam logic [4:0] LOOP_MIN_OK = 5'h04;

   // Ring hold time
   localparam longint CLK_HZ = 100000000;
   localparam longint RING_HOLD_S = 5;
   localparam longint RING_HOLD_CYC = RING_HOLD_S * CLK_HZ;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sample rate in Hz for a rate code; reserved codes give zero
   function automatic logic [15:0] rate_hz(input logic [3:0] c);
      case (c)
         4'h0: rate_hz = 16'h1C20;
         4'h1: rate_hz = 16'h1F40;
         4'h2: rate_hz = 16'h2025;
         4'h3: rate_hz = 16'h20D0;
         4'h4: rate_hz = 16'h2328;
         4'h5: rate_hz = 16'h2580;
         4'h6: rate_hz = 16'h282E;
         4'h7: rate_hz = 16'h2EE0;
         4'h8: rate_hz = 16'h3592;
         4'h9: rate_hz = 16'h3E80;
         default: rate_hz = 16'h0000;
      endcase
   endfunction
endpackage

// ===== daalcs_regs.sv
// Added by the designer: the AXI4-Lite interface to the registers.
module daalcs_regs
   import daalcs_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int SAMPLE_W = 16,
   parameter longint RING_HOLD = RING_HOLD_CYC,
   parameter logic [3:0] LINESIDE_ID = 4'h6, // Arbitrary identity value
   parameter logic [3:0] SYS_REV = 4'h1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Line-side status pins, asynchronous
   input wire logic ring_pos_in,
   input wire logic ring_neg_in,
   input wire logic frame_lock_in,
   input wire logic [4:0] loop_current_in,
   // Sample path
   input wire logic [SAMPLE_W-1:0] tx_sample,
   input wire logic [SAMPLE_W-1:0] line_rx_sample,
   output logic [SAMPLE_W-1:0] rx_sample,
   // Line control
   output logic offhook,
   output logic onhook_monitor,
   output logic lineside_pd,
   output logic logic_pd,
   output logic [3:0] sample_rate_code,
   output logic [15:0] sample_rate_hz,
   output logic loop_overload_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Address helpers
   function automatic logic [3:0] reg_idx(input logic [ADDR_W-1:0] a);
      reg_idx = a[5:2];
   endfunction

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
      reg_mapped = (a[1:0] == 2'h0) && ((a >> 6) == '0)
         && (a[5:2] >= IDX_IRQ_MASK) && (a[5:2] <= IDX_LSTAT);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage feeds only the second
   logic [7:0] meta_q;
   logic [7:0] sync_q;
   logic frame_prev_q;
   wire logic [7:0] pins = {loop_current_in, frame_lock_in, ring_neg_in, ring_pos_in};
   wire logic ring_pos_s = sync_q[0];
   wire logic ring_neg_s = sync_q[1];
   wire logic frame_s = sync_q[2];
   wire logic [4:0] level_s = sync_q[7:3];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
         frame_prev_q <= 1'b0;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
         frame_prev_q <= frame_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data held separately, response after both
   logic aw_full_q;
   logic w_full_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [ADDR_W-1:0] wa_q;
   logic [7:0] wd_q;
   logic ws_q;

   wire logic aw_take = awvalid && awready_q;
   wire logic w_take = wvalid && wready_q;
   wire logic wr_fire = aw_full_q && w_full_q && !bvalid_q;
   wire logic aw_full_d = aw_take || (aw_full_q && !wr_fire);
   wire logic w_full_d = w_take || (w_full_q && !wr_fire);
   wire logic bvalid_d = wr_fire || (bvalid_q && !bready);
   wire logic wr_ok = reg_mapped(wa_q);
   wire logic [3:0] wr_idx = reg_idx(wa_q);
   // Only byte lane 0 carries register bits; other lanes are dropped
   wire logic wr_en = wr_fire && wr_ok && ws_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awready_q <= !aw_full_d && !bvalid_d;
         wready_q <= !w_full_d && !bvalid_d;
         bvalid_q <= bvalid_d;
         if (wr_fire) begin
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Payload capture, no reset needed on data
   always_ff @(posedge aclk) begin
      if (aw_take) begin
         wa_q <= awaddr;
      end
      if (w_take) begin
         wd_q <= wdata[7:0];
         ws_q <= wstrb[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write decode per register
   wire logic wr_hook = wr_en && (wr_idx == IDX_HOOK);
   wire logic wr_pwr = wr_en && (wr_idx == IDX_PWR);
   wire logic wr_rate = wr_en && (wr_idx == IDX_RATE);
   wire logic wr_loop = wr_en && (wr_idx == IDX_LOOP);
   wire logic wr_mask = wr_en && (wr_idx == IDX_IRQ_MASK);
   wire logic wr_stat = wr_en && (wr_idx == IDX_IRQ_STAT);
   // Reserved codes are refused so the converter never sees them
   wire logic rate_legal = wd_q[3:0] <= RATE_LAST;

   ////////////////////////////////////////////////////////////////////////
   // Control fields written by software
   logic offhook_q;
   logic onhook_monitor_enable_q;
   logic lineside_powerdown_q;
   logic logic_powerdown_q;
   logic logic_down_q;
   logic [3:0] rate_q;
   logic digital_loopback_enable_q;
   logic ovl_mask_q;
   logic floss_mask_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offhook_q <= RST_OFFHOOK;
         onhook_monitor_enable_q <= RST_MONITOR;
         lineside_powerdown_q <= RST_LINE_PD;
         logic_powerdown_q <= RST_LOGIC_PD;
         logic_down_q <= RST_LOGIC_PD;
         rate_q <= RST_RATE;
         digital_loopback_enable_q <= RST_LOOPBACK;
         ovl_mask_q <= 1'b0;
         floss_mask_q <= 1'b0;
      end else begin
         // Read-only hook bits have no flop here, so writes to them fall away
         if (wr_hook) begin
            offhook_q <= wd_q[B_OFFHOOK];
            onhook_monitor_enable_q <= wd_q[B_MONITOR];
         end
         if (wr_pwr) begin
            lineside_powerdown_q <= wd_q[B_LINE_PD];
            logic_powerdown_q <= wd_q[B_LOGIC_PD];
         end
         // Once down, only aresetn brings the logic back
         if (wr_pwr && wd_q[B_LOGIC_PD]) begin
            logic_down_q <= 1'b1;
         end
         if (wr_rate && rate_legal) begin
            rate_q <= wd_q[3:0];
         end
         if (wr_loop) begin
            digital_loopback_enable_q <= wd_q[B_LOOPBACK];
         end
         if (wr_mask) begin
            ovl_mask_q <= wd_q[B_OVL];
            floss_mask_q <= wd_q[B_FLOSS];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ring detect: hold counter reloads on each positive ring while on-hook; off-hook holds it at zero
   logic ring_q;
   logic [31:0] hold_q;
   wire logic [31:0] hold_d = ring_pos_s ? 32'(RING_HOLD)
      : (hold_q != 32'h0) ? hold_q - 32'h1 : 32'h0;
   // Off-hook clears the flag at once, whatever the line shows
   wire logic ring_d = !offhook_q && (ring_pos_s || ring_neg_s || (hold_d != 32'h0));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ring_q <= 1'b0;
         hold_q <= 32'h0;
      end else begin
         ring_q <= ring_d;
         hold_q <= offhook_q ? 32'h0 : hold_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Loop current level and sticky status; a set beats a clear
   logic [4:0] level_q;
   logic [4:0] level_prev_q;
   logic ovl_q;
   logic floss_q;
   // Level bits cross one by one; a word counts only once two samples agree
   wire logic level_steady = (level_s == level_prev_q);
   wire logic ovl_set = offhook_q && level_steady && (level_s == LOOP_SAT);
   wire logic floss_set = frame_prev_q && !frame_s;
   wire logic ovl_clr = wr_stat && !wd_q[B_OVL];
   wire logic floss_clr = wr_stat && !wd_q[B_FLOSS];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= 5'h00;
         level_prev_q <= 5'h00;
         ovl_q <= 1'b0;
         floss_q <= 1'b0;
      end else begin
         level_prev_q <= level_s;
         level_q <= !offhook_q ? 5'h00 : level_steady ? level_s : level_q;
         ovl_q <= ovl_set || (ovl_q && !ovl_clr);
         floss_q <= floss_set || (floss_q && !floss_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle from address to data
   logic arready_q;
   logic rvalid_q;
   logic [7:0] rd_q;
   logic [1:0] rresp_q;
   logic [7:0] rd_word;
   wire logic ar_take = arvalid && arready_q;
   wire logic rvalid_d = ar_take || (rvalid_q && !rready);
   wire logic rd_ok = reg_mapped(araddr);

   // Read selection; status bits come live from the pins and flags
   always_comb begin
      rd_word = 8'h00;
      case (reg_idx(araddr))
         IDX_HOOK: rd_word = {1'b0, ring_neg_s, ring_pos_s, 1'b0,
            onhook_monitor_enable_q, ring_q, 1'b0, offhook_q};
         IDX_PWR: rd_word = {3'h0, lineside_powerdown_q, logic_powerdown_q, 3'h0};
         IDX_RATE: rd_word = {4'h0, rate_q};
         IDX_LOOP: rd_word = {7'h00, digital_loopback_enable_q};
         IDX_REV: rd_word = {LINESIDE_ID, SYS_REV};
         IDX_LSTAT: rd_word = {1'b0, frame_s, 1'b0, level_q};
         IDX_IRQ_MASK: rd_word = {2'h0, floss_mask_q, 2'h0, ovl_mask_q, 2'h0};
         IDX_IRQ_STAT: rd_word = {2'h0, floss_q, 2'h0, ovl_q, 2'h0};
         default: rd_word = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rd_q <= 8'h00;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= !rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_take) begin
            rd_q <= rd_ok ? rd_word : 8'h00;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Datapath and line outputs, all registered
   logic [SAMPLE_W-1:0] rx_q;
   logic irq_q;
   logic [15:0] hz_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_q <= '0;
         irq_q <= 1'b0;
         hz_q <= 16'h0000;
      end else begin
         // Loopback bypasses the filters, so samples pass untouched
         rx_q <= digital_loopback_enable_q ? tx_sample : line_rx_sample;
         irq_q <= (ovl_q && ovl_mask_q) || (floss_q && floss_mask_q);
         hz_q <= rate_hz(rate_q);
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = {24'h000000, rd_q};
   assign rresp = rresp_q;
   assign rx_sample = rx_q;
   assign offhook = offhook_q;
   assign onhook_monitor = onhook_monitor_enable_q;
   assign lineside_pd = lineside_powerdown_q;
   assign logic_pd = logic_down_q;
   assign sample_rate_code = rate_q;
   assign sample_rate_hz = hz_q;
   assign loop_overload_irq = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_ring_offhook_clear: assert property (offhook_q |=> !ring_q)
      else $error("ring flag survived off-hook");
   a_ring_follows: assert property ((!offhook_q && ring_pos_s && !wr_hook) |=> ring_q [*2])
      else $error("ring flag not held after positive ring");
   a_hook_rd_ring: assert property ((ar_take && rd_ok && reg_idx(araddr) == IDX_HOOK)
      |=> rd_q[6:5] == $past({ring_neg_s, ring_pos_s}))
      else $error("ring indicators misreported");
   a_offhook_write: assert property (wr_hook |=> offhook == $past(wd_q[B_OFFHOOK]))
      else $error("hook bit not taken");
   a_logic_down_hold: assert property (logic_pd |=> logic_pd)
      else $error("logic power-down released without reset");
   a_rate_legal: assert property (sample_rate_code <= RATE_LAST)
      else $error("reserved rate code in use");
   a_loopback_path: assert property (digital_loopback_enable_q
      |=> rx_sample == $past(tx_sample))
      else $error("loopback sample differs");
   a_rev_fixed: assert property ((ar_take && rd_ok && reg_idx(araddr) == IDX_REV)
      |=> rdata[7:0] == {LINESIDE_ID, SYS_REV})
      else $error("revision register altered");
   a_level_onhook: assert property (!offhook_q |=> level_q == 5'h00)
      else $error("loop level shown on-hook");
   a_overload_irq: assert property ((ovl_set && ovl_mask_q && !wr_mask)
      |-> ##2 loop_overload_irq)
      else $error("overload interrupt missing");
   a_frame_loss_set: assert property (floss_set |=> floss_q)
      else $error("frame loss not recorded");
   a_bresp_after_both: assert property (wr_fire |=> bvalid && !awready && !wready)
      else $error("write response timing");

   c_write_done: cover property (bvalid && bready);
   c_read_done: cover property (rvalid && rready && rresp == RESP_OKAY);
   c_ring_seen: cover property (ring_q ##1 !ring_q);
   c_overload: cover property (ovl_set && ovl_mask_q);
endmodule

// ===== daalcs_line_model.sv
// Line-side stand-in driven by the bench's stimulus wishes
module daalcs_line_model (
   // Clock
   input wire logic aclk,
   // Wishes from the bench
   input wire logic offhook,
   input wire logic [4:0] level_set,
   input wire logic lock_set,
   input wire logic [1:0] ring_set,
   // Line-side pins
   output logic ring_pos_in,
   output logic ring_neg_in,
   output logic frame_lock_in,
   output logic [4:0] loop_current_in,
   output logic [15:0] line_rx_sample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] pat_q = 16'h0001;
   ////////////////////////////////////////////////////////////////////////////////////////
   // Ring polarity and frame lock are plain levels from the line
   assign ring_pos_in = ring_set[0];
   assign ring_neg_in = ring_set[1];
   assign frame_lock_in = lock_set;
   // No loop current can flow while the line is on-hook
   assign loop_current_in = offhook ? level_set : 5'h00;
   // Samples change every cycle so a stale one never matches by luck
   always @(posedge aclk) pat_q <= pat_q * 16'h0005 + 16'h3C01;
   assign line_rx_sample = pat_q;
endmodule

// ===== tb_daa_line_control_status_regs.sv
module tb_daa_line_control_status_regs
   import daalcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] ID_V = 4'h6; // Arbitrary identity value
   localparam logic [3:0] REV_V = 4'h1;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic ring_pos_in, ring_neg_in, frame_lock_in;
   logic [4:0] loop_current_in;
   logic [15:0] tx_sample = 16'h0;
   logic [15:0] line_rx_sample, rx_sample, sample_rate_hz;
   logic offhook, onhook_monitor, lineside_pd, logic_pd, loop_overload_irq;
   logic [3:0] sample_rate_code;
   logic [4:0] level_set = 5'h00;
   logic lock_set = 1'b0;
   logic [1:0] ring_set = 2'b00;
   int bad_count = 0;
   int checks_done = 0;

   daalcs_regs #(.RING_HOLD(60), .LINESIDE_ID(ID_V), .SYS_REV(REV_V)) u_daalcs_regs (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .ring_pos_in(ring_pos_in), .ring_neg_in(ring_neg_in),
      .frame_lock_in(frame_lock_in), .loop_current_in(loop_current_in),
      .tx_sample(tx_sample), .line_rx_sample(line_rx_sample), .rx_sample(rx_sample),
      .offhook(offhook), .onhook_monitor(onhook_monitor), .lineside_pd(lineside_pd),
      .logic_pd(logic_pd), .sample_rate_code(sample_rate_code),
      .sample_rate_hz(sample_rate_hz), .loop_overload_irq(loop_overload_irq));
   daalcs_line_model u_daalcs_line_model (
      .aclk(aclk), .offhook(offhook), .level_set(level_set), .lock_set(lock_set),
      .ring_set(ring_set), .ring_pos_in(ring_pos_in), .ring_neg_in(ring_neg_in),
      .frame_lock_in(frame_lock_in), .loop_current_in(loop_current_in),
      .line_rx_sample(line_rx_sample));
   ////////////////////////////////////////////////////////////////////////////////////////
   // Verdict and run end
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Value compare; an unknown never matches
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // A wait that used up its bound ends the run
   task automatic tmo(input int n);
      if (n >= 100) begin
         bad_count++;
         $display("[ERR] bus handshake expected within 100 cycles seen none");
         tally_and_finish();
      end
   endtask
   function automatic logic [7:0] ba(input logic [3:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   function automatic logic [31:0] hz_of(input logic [3:0] c);
      int t[10] = '{7200, 8000, 8229, 8400, 9000, 9600, 10286, 12000, 13714, 16000};
      return t[c];
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////
   // Bus master: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ad;
      logic wd;
      n = 0;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end while (!(ad && wd) && n < 100);
      while (bvalid !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      tmo(n);
      bready <= 1'b0;
      chk("write response", {30'h0, er}, {30'h0, bresp});
   endtask
   // Read and compare data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 100);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      tmo(n);
      rready <= 1'b0;
      chk("read data", e, rdata);
      chk("read response", {30'h0, er}, {30'h0, rresp});
   endtask
   task automatic note(input string nm);
      $display("Test %s finished", nm);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      forever #5 aclk = ~aclk;
   end
   // Main sequence
   initial begin
      int seed_v;
      logic [4:0] lvl;
      logic [3:0] last;
      logic [15:0] prev;
      seed_v = $urandom(82811);
      last = RST_RATE;
      prev = 16'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("lineside_pd", 32'h1, {31'h0, lineside_pd});
      chk("rate_hz", 32'd8000, {16'h0, sample_rate_hz});
      rd(ba(IDX_HOOK), 32'h0, RESP_OKAY);
      rd(ba(IDX_PWR), 32'h10, RESP_OKAY);
      rd(ba(IDX_REV), {24'h0, ID_V, REV_V}, RESP_OKAY);
      wr(ba(IDX_REV), 32'h0, RESP_OKAY);
      rd(ba(IDX_REV), {24'h0, ID_V, REV_V}, RESP_OKAY);
      wr(8'h40, 32'h0, RESP_SLVERR);
      rd(8'h40, 32'h0, RESP_SLVERR);
      note("reset and map");
      // Every rate code; reserved codes keep the previous one
      for (int c = 0; c < 16; c++) begin
         wr(ba(IDX_RATE), c, RESP_OKAY);
         if (c < 10) last = c[3:0];
         rd(ba(IDX_RATE), {28'h0, last}, RESP_OKAY);
         chk("rate_hz", hz_of(last), {16'h0, sample_rate_hz});
         chk("rate_code", {28'h0, last}, {28'h0, sample_rate_code});
      end
      note("rates");
      wr(ba(IDX_HOOK), 32'h08, RESP_OKAY);
      rd(ba(IDX_HOOK), 32'h08, RESP_OKAY);
      chk("onhook_monitor", 32'h1, {31'h0, onhook_monitor});
      wr(ba(IDX_HOOK), 32'h0, RESP_OKAY);
      // Live ring levels, then the hold after the last positive ring
      ring_set <= 2'b01;
      repeat (6) @(posedge aclk);
      rd(ba(IDX_HOOK), 32'h24, RESP_OKAY);
      ring_set <= 2'b10;
      repeat (6) @(posedge aclk);
      rd(ba(IDX_HOOK), 32'h44, RESP_OKAY);
      ring_set <= 2'b00;
      repeat (8) @(posedge aclk);
      rd(ba(IDX_HOOK), 32'h04, RESP_OKAY);
      repeat (70) @(posedge aclk);
      rd(ba(IDX_HOOK), 32'h0, RESP_OKAY);
      // Going off-hook drops a held ring flag; read-only bits ignore the write
      ring_set <= 2'b01;
      repeat (4) @(posedge aclk);
      ring_set <= 2'b00;
      wr(ba(IDX_HOOK), 32'h65, RESP_OKAY);
      rd(ba(IDX_HOOK), 32'h01, RESP_OKAY);
      chk("offhook", 32'h1, {31'h0, offhook});
      note("hook and ring");
      lock_set <= 1'b1;
      lvl = 5'($urandom_range(30, 0));
      level_set <= lvl;
      repeat (6) @(posedge aclk);
      rd(ba(IDX_LSTAT), {25'h0, 2'b10, lvl}, RESP_OKAY);
      wr(ba(IDX_LSTAT), 32'h0, RESP_OKAY);
      rd(ba(IDX_LSTAT), {25'h0, 2'b10, lvl}, RESP_OKAY);
      level_set <= LOOP_SAT;
      repeat (6) @(posedge aclk);
      rd(ba(IDX_LSTAT), 32'h5F, RESP_OKAY);
      rd(ba(IDX_IRQ_STAT), 32'h04, RESP_OKAY);
      chk("irq", 32'h0, {31'h0, loop_overload_irq});
      wr(ba(IDX_IRQ_MASK), 32'h04, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, loop_overload_irq});
      level_set <= LOOP_MIN_OK;
      repeat (6) @(posedge aclk);
      wr(ba(IDX_IRQ_STAT), 32'h0, RESP_OKAY);
      rd(ba(IDX_IRQ_STAT), 32'h0, RESP_OKAY);
      chk("irq", 32'h0, {31'h0, loop_overload_irq});
      lock_set <= 1'b0;
      repeat (6) @(posedge aclk);
      rd(ba(IDX_IRQ_STAT), 32'h20, RESP_OKAY);
      rd(ba(IDX_LSTAT), 32'h04, RESP_OKAY);
      wr(ba(IDX_IRQ_MASK), 32'h20, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, loop_overload_irq});
      wr(ba(IDX_HOOK), 32'h0, RESP_OKAY);
      repeat (6) @(posedge aclk);
      rd(ba(IDX_LSTAT), 32'h0, RESP_OKAY);
      chk("offhook", 32'h0, {31'h0, offhook});
      note("loop current and link");
      // Receive path: line samples, then transmit looped back
      for (int m = 0; m < 2; m++) begin
         wr(ba(IDX_LOOP), m, RESP_OKAY);
         rd(ba(IDX_LOOP), m, RESP_OKAY);
         for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            tx_sample <= 16'($urandom);
            @(negedge aclk);
            if (i > 0) chk("rx_sample", {16'h0, prev}, {16'h0, rx_sample});
            prev = (m == 1) ? tx_sample : line_rx_sample;
         end
      end
      note("loopback");
      wr(ba(IDX_PWR), 32'h0, RESP_OKAY);
      chk("lineside_pd", 32'h0, {31'h0, lineside_pd});
      wr(ba(IDX_PWR), 32'h08, RESP_OKAY);
      wr(ba(IDX_PWR), 32'h0, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("logic_pd", 32'h1, {31'h0, logic_pd});
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("logic_pd", 32'h0, {31'h0, logic_pd});
      chk("lineside_pd", 32'h1, {31'h0, lineside_pd});
      note("power down");
      tally_and_finish();
   end
endmodule
